// [verilog/acsbt_timer.sv]
// Register access over APB and the address map are this design's own decisions.
module acsbt_timer
    import acsbt_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ext_timer_clock_pin,
    input  wire logic        gate_pin,
    input  wire logic        cpu_idle,
    output logic             timer_flag,
    output logic      [15:0] count_value
);
    import acsbt_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [15:0] ctrl;
    logic [15:0] period;
    logic [15:0] pend_value;
    acsbt_wr_t   wr_state;
    logic [2:0]  sync_ff [2];
    logic [1:0]  pin_lvl;
    logic        ext_rise;
    logic        bus_wr;
    logic        bus_rd;
    logic        async_mode;
    logic        run;
    logic        src_tick;
    logic        cnt_tick;
    logic        cnt_load;
    logic [15:0] cnt_load_val;
    logic        count_wr;
    logic        wr_taken;
    logic        wip_bit;
    logic [15:0] ctrl_rd;
    logic [2:0]  idx;
    logic        idx_ok;
    logic [31:0] rd_word;

    function automatic logic [2:0] reg_index(input logic [7:0] a);
        reg_index = a[4:2];
    endfunction

    function automatic logic reg_valid(input logic [7:0] a);
        reg_valid = (a[1:0] == 2'b00) && (a <= ACSBT_OFS_STATUS);
    endfunction

    function automatic logic [15:0] ctrl_apply(input acsbt_op_t op,
                                               input logic [15:0] old,
                                               input logic [15:0] w);
        logic [15:0] m;
        m = w & ACSBT_CTRL_WMASK;
        unique case (op)
            ACSBT_OP_WRITE: ctrl_apply = m;
            ACSBT_OP_CLR:   ctrl_apply = old & ~m;
            ACSBT_OP_SET:   ctrl_apply = old | m;
            ACSBT_OP_INV:   ctrl_apply = old ^ m;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    // One wait state: pready pulses in the second access cycle
    // Unmapped or misaligned writes must not alias onto a register
    assign bus_wr = psel && penable && !pready && pwrite && idx_ok;
    assign bus_rd = psel && penable && !pready && !pwrite;
    assign idx    = reg_index(paddr);
    assign idx_ok = reg_valid(paddr);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !idx_ok;
        end
    end

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Edge accepted only once stages two and three agree
    for (genvar g = 0; g < 2; g++)
    begin : g_pin
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                sync_ff[g] <= 3'b000;
                pin_lvl[g] <= 1'b0;
            end
            else
            begin
                sync_ff[g] <= {sync_ff[g][1:0],
                               (g == 0) ? ext_timer_clock_pin : gate_pin};
                if (sync_ff[g][1] == sync_ff[g][2])
                    pin_lvl[g] <= sync_ff[g][2];
            end
        end
    end

    assign ext_rise = (sync_ff[0][1] == sync_ff[0][2]) && sync_ff[0][2] && !pin_lvl[0];

    // ------------------------------------------------------------
    // Clock source and gating
    // ------------------------------------------------------------
    assign async_mode = ctrl[ACSBT_B_CS] && !ctrl[ACSBT_B_SYNC];
    assign run = ctrl[ACSBT_B_ON] && !(ctrl[ACSBT_B_HALT] && cpu_idle);

    always_comb
    begin
        if (ctrl[ACSBT_B_CS])
            src_tick = ext_rise;
        else if (ctrl[ACSBT_B_GATE])
            src_tick = pin_lvl[1];
        else
            src_tick = 1'b1;
    end

    acsbt_prescale u_prescale (
        .pclk            (pclk),
        .presetn         (presetn),
        .clear           (!run),
        .in_tick         (src_tick),
        .prescale_select (ctrl[ACSBT_B_PS_HI:ACSBT_B_PS_LO]),
        .out_tick        (cnt_tick)
    );

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl <= ACSBT_CTRL_RESET;
        else if (bus_wr && idx_ok && idx < 3'd4)
            ctrl <= ctrl_apply(acsbt_op_t'(idx[1:0]), ctrl, pwdata[15:0]);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            period <= ACSBT_PERIOD_RESET;
        else if (bus_wr && idx == ACSBT_OFS_PERIOD[4:2])
            period <= pwdata[15:0];
    end

    // ------------------------------------------------------------
    // Count write handshake
    // ------------------------------------------------------------
    // In async mode a write waits for the next external edge, as
    // the counter belongs to the pin's time base there
    assign count_wr = bus_wr && idx == ACSBT_OFS_COUNT[4:2];
    assign wr_taken = count_wr &&
                      !(ctrl[ACSBT_B_WBLK] && wr_state == ACSBT_WR_PEND);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_state   <= ACSBT_WR_IDLE;
            pend_value <= ACSBT_COUNT_RESET;
        end
        else
        begin
            unique case (wr_state)
                ACSBT_WR_IDLE:
                    if (wr_taken && async_mode)
                    begin
                        wr_state   <= ACSBT_WR_PEND;
                        pend_value <= pwdata[15:0];
                    end
                ACSBT_WR_PEND:
                    if (wr_taken)
                        pend_value <= pwdata[15:0];
                    else if (ext_rise || !async_mode)
                        wr_state <= ACSBT_WR_IDLE;
            endcase
        end
    end

    assign wip_bit = (wr_state == ACSBT_WR_PEND) && async_mode;

    always_comb
    begin
        cnt_load     = 1'b0;
        cnt_load_val = pend_value;
        if (wr_taken && !async_mode)
        begin
            cnt_load     = 1'b1;
            cnt_load_val = pwdata[15:0];
        end
        else if (wr_state == ACSBT_WR_PEND && !wr_taken && (ext_rise || !async_mode))
            cnt_load = 1'b1;
    end

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    // Slow secondary oscillator works here as any external clock
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            count_value <= ACSBT_COUNT_RESET;
        else if (cnt_load)
            count_value <= cnt_load_val;
        else if (cnt_tick)
            count_value <= (count_value == period) ? 16'h0000
                                                   : count_value + 16'h0001;
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            timer_flag <= 1'b0;
        else if (cnt_tick && !cnt_load && count_value == period)
            timer_flag <= 1'b1;
        else if (bus_wr && idx == ACSBT_OFS_STATUS[4:2] && pwdata[0])
            timer_flag <= 1'b0;
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_comb
    begin
        ctrl_rd              = ctrl & ACSBT_CTRL_WMASK;
        ctrl_rd[ACSBT_B_WIP] = wip_bit;
        unique case (idx)
            3'd0, 3'd1, 3'd2, 3'd3: rd_word = {16'h0000, ctrl_rd};
            3'd4:                   rd_word = {16'h0000, count_value};
            3'd5:                   rd_word = {16'h0000, period};
            3'd6:                   rd_word = {31'h0, timer_flag};
            default:                rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (bus_rd)
            prdata <= idx_ok ? rd_word : 32'h0000_0000;
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_access_wait;
        psel && penable && !pready;
    endsequence

    sequence s_answer;
        pready ##1 !pready;
    endsequence

    property p_one_wait;
        s_access_wait |=> s_answer;
    endproperty

    a_bus_answer: assert property (p_one_wait)
        else $error("pready not a single pulse after access");

    a_ctrl_reserved: assert property (
        pready && !pslverr && !pwrite && paddr <= ACSBT_OFS_INV
        |-> (prdata & 32'hffff_4749) == 32'h0)
        else $error("reserved control bits read nonzero");

    a_count_wrap: assert property (
        (cnt_tick && !cnt_load && count_value == period)
        |=> count_value == 16'h0000 && timer_flag)
        else $error("counter did not wrap at period");

    a_count_step: assert property (
        (cnt_tick && !cnt_load && count_value != period)
        |=> count_value == $past(count_value) + 16'h0001)
        else $error("counter did not step by one");

    a_off_hold: assert property (
        (!ctrl[ACSBT_B_ON] && !cnt_load) |=> count_value == $past(count_value))
        else $error("counter moved while disabled");

    a_idle_halt: assert property (
        (ctrl[ACSBT_B_HALT] && cpu_idle) |-> !cnt_tick)
        else $error("counter ticked while halted in idle");

    a_gate_block: assert property (
        (!ctrl[ACSBT_B_CS] && ctrl[ACSBT_B_GATE] && !pin_lvl[1]) |-> !src_tick)
        else $error("gated tick with gate low");

    a_write_block: assert property (
        (count_wr && ctrl[ACSBT_B_WBLK] && wr_state == ACSBT_WR_PEND)
        |=> $stable(pend_value))
        else $error("blocked count write was taken");

    a_wip_sync: assert property (
        !async_mode |-> !wip_bit)
        else $error("write pending shown in sync mode");

    a_alias_set: assert property (
        (bus_wr && paddr == ACSBT_OFS_SET)
        |=> ctrl == ($past(ctrl) | ($past(pwdata[15:0]) & ACSBT_CTRL_WMASK)))
        else $error("set alias did not set bits");

endmodule

// [verilog/acsbt_pkg.sv]
package acsbt_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ACSBT_OFS_CTRL   = 8'h00;
    localparam logic [7:0] ACSBT_OFS_CLR    = 8'h04;
    localparam logic [7:0] ACSBT_OFS_SET    = 8'h08;
    localparam logic [7:0] ACSBT_OFS_INV    = 8'h0c;
    localparam logic [7:0] ACSBT_OFS_COUNT  = 8'h10;
    localparam logic [7:0] ACSBT_OFS_PERIOD = 8'h14;
    localparam logic [7:0] ACSBT_OFS_STATUS = 8'h18;

    // ------------------------------------------------------------
    // Control field positions
    // ------------------------------------------------------------
    localparam int ACSBT_B_ON    = 15;
    localparam int ACSBT_B_HALT  = 13;
    localparam int ACSBT_B_WBLK  = 12;
    localparam int ACSBT_B_WIP   = 11;
    localparam int ACSBT_B_GATE  = 7;
    localparam int ACSBT_B_PS_HI = 5;
    localparam int ACSBT_B_PS_LO = 4;
    localparam int ACSBT_B_SYNC  = 2;
    localparam int ACSBT_B_CS    = 1;

    // Bits software may write; the pending flag is read-only
    localparam logic [15:0] ACSBT_CTRL_WMASK  = 16'hb0b6;
    localparam logic [15:0] ACSBT_CTRL_RESET  = 16'h0000;
    localparam logic [15:0] ACSBT_COUNT_RESET = 16'h0000;
    localparam logic [15:0] ACSBT_PERIOD_RESET = 16'hffff;

    // ------------------------------------------------------------
    // Prescale terminal counts (divide minus one)
    // ------------------------------------------------------------
    localparam logic [7:0] ACSBT_PS_TERM_1   = 8'h00;
    localparam logic [7:0] ACSBT_PS_TERM_8   = 8'h07;
    localparam logic [7:0] ACSBT_PS_TERM_64  = 8'h3f;
    localparam logic [7:0] ACSBT_PS_TERM_256 = 8'hff;

    typedef enum logic [1:0] {
        ACSBT_OP_WRITE = 2'b00,
        ACSBT_OP_CLR   = 2'b01,
        ACSBT_OP_SET   = 2'b10,
        ACSBT_OP_INV   = 2'b11
    } acsbt_op_t;

    typedef enum logic {
        ACSBT_WR_IDLE = 1'b0,
        ACSBT_WR_PEND = 1'b1
    } acsbt_wr_t;

endpackage

// [verilog/acsbt_prescale.sv]
module acsbt_prescale
    import acsbt_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       clear,
    input  wire logic       in_tick,
    input  wire logic [1:0] prescale_select,
    output logic            out_tick
);

    logic [7:0] div_cnt;
    logic [7:0] term;

    function automatic logic [7:0] term_of(input logic [1:0] sel);
        unique case (sel)
            2'b00: term_of = ACSBT_PS_TERM_1;
            2'b01: term_of = ACSBT_PS_TERM_8;
            2'b10: term_of = ACSBT_PS_TERM_64;
            2'b11: term_of = ACSBT_PS_TERM_256;
        endcase
    endfunction

    assign term = term_of(prescale_select);

    // Counter restarts on disable so the first period is always full
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            div_cnt <= 8'h00;
        else if (clear)
            div_cnt <= 8'h00;
        else if (in_tick)
            div_cnt <= (div_cnt >= term) ? 8'h00 : div_cnt + 8'h01;
    end

    assign out_tick = in_tick && !clear && (div_cnt >= term);

endmodule

// [test/acsbt_ext_src.sv]
module acsbt_ext_src (
    output logic clk_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Slow oscillator model
    // ------------------------------------------------------------
    // Stands low between bursts; phase unrelated to pclk on purpose
    initial clk_out = 1'b0;

    task automatic pulses(input int n);
        repeat (n)
        begin
            #36.9 clk_out = 1'b1;
            #36.9 clk_out = 1'b0;
        end
    endtask
endmodule

// [test/acsbt_timer_tb.sv]
module acsbt_timer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import acsbt_pkg::*;

    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        ext_clk;
    logic        gate_pin = 1'b0;
    logic        cpu_idle = 1'b0;
    logic        timer_flag;
    logic [15:0] count_value;
    logic [31:0] rd;
    logic        err;
    int          mismatches = 0;
    int          n_compared = 0;

    always #4 pclk = ~pclk;

    acsbt_timer DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_timer_clock_pin(ext_clk), .gate_pin(gate_pin),
        .cpu_idle(cpu_idle), .timer_flag(timer_flag), .count_value(count_value));

    acsbt_ext_src SRC (.clk_out(ext_clk));

    // ------------------------------------------------------------
    // Bus and compare helpers
    // ------------------------------------------------------------
    // Always leaves an idle cycle after a transfer, so no access
    // follows a disabling write at once
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic rng(input string nm, input logic [31:0] lo, hi, g);
        n_compared++;
        if (((g >= lo) && (g <= hi)) !== 1'b1)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h..%h seen %h", nm, lo, hi, g);
        end
    endtask

    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask

    task automatic rrng(input string nm, input logic [31:0] lo, hi);
        apb(1'b0, ACSBT_OFS_COUNT, 32'h0);
        rng(nm, lo, hi, rd);
    endtask

    task automatic test_done;
        if (mismatches == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        rchk("ctrl reset", ACSBT_OFS_CTRL, 32'h0);
        chk("count pin", 32'h0, {16'h0, count_value});
        wr(ACSBT_OFS_CTRL, 32'hffff_ffff);
        rchk("ctrl mask", ACSBT_OFS_CTRL, 32'h0000_b0b6);
        wr(ACSBT_OFS_CTRL, 32'h0);
    endtask

    task automatic t_alias;
        wr(ACSBT_OFS_SET, 32'hffff_2030);
        rchk("set alias", ACSBT_OFS_CTRL, 32'h0000_2030);
        wr(ACSBT_OFS_CLR, 32'h0000_2000);
        rchk("clr alias", ACSBT_OFS_CTRL, 32'h0000_0030);
        wr(ACSBT_OFS_INV, 32'h0000_0014);
        rchk("inv alias", ACSBT_OFS_INV, 32'h0000_0024);
        wr(ACSBT_OFS_CTRL, 32'h0);
    endtask

    task automatic t_bus_err;
        apb(1'b0, 8'h1c, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
        apb(1'b1, 8'h02, 32'hffff_ffff);
        chk("misaligned err", 32'h1, {31'h0, err});
        rchk("ctrl untouched", ACSBT_OFS_CTRL, 32'h0);
        apb(1'b1, 8'h34, 32'h0000_0000);
        chk("unmapped wr err", 32'h1, {31'h0, err});
        rchk("period untouched", ACSBT_OFS_PERIOD, 32'h0000_ffff);
    endtask

    task automatic t_prescale;
        int div;
        for (int p = 0; p < 4; p++)
        begin
            div = (p == 0) ? 1 : (p == 1) ? 8 : (p == 2) ? 64 : 256;
            wr(ACSBT_OFS_COUNT, 32'h0);
            wr(ACSBT_OFS_CTRL, 32'h8000 | (p << 4));
            repeat (4 * div - 3) @(posedge pclk);
            wr(ACSBT_OFS_CTRL, 32'h0);
            rrng("prescaled count", 32'h3, 32'h5);
        end
    endtask

    task automatic t_gate;
        wr(ACSBT_OFS_COUNT, 32'h0);
        wr(ACSBT_OFS_CTRL, 32'h8080);
        repeat (30) @(posedge pclk);
        rchk("gate closed", ACSBT_OFS_COUNT, 32'h0);
        gate_pin <= 1'b1;
        repeat (30) @(posedge pclk);
        wr(ACSBT_OFS_CTRL, 32'h0);
        rrng("gate open", 32'd20, 32'd40);
        gate_pin <= 1'b0;
    endtask

    task automatic t_idle;
        cpu_idle <= 1'b1;
        wr(ACSBT_OFS_COUNT, 32'h0);
        wr(ACSBT_OFS_CTRL, 32'ha000);
        repeat (30) @(posedge pclk);
        rchk("halted idle", ACSBT_OFS_COUNT, 32'h0);
        wr(ACSBT_OFS_CTRL, 32'h8000);
        repeat (30) @(posedge pclk);
        wr(ACSBT_OFS_CTRL, 32'h0);
        rrng("running idle", 32'd28, 32'd40);
        cpu_idle <= 1'b0;
    endtask

    task automatic t_ext;
        // Gate bit set and gate low: must not matter for the pin clock
        wr(ACSBT_OFS_CTRL, 32'h0006);
        wr(ACSBT_OFS_COUNT, 32'h0);
        rchk("sync no pending", ACSBT_OFS_CTRL, 32'h0006);
        wr(ACSBT_OFS_CTRL, 32'h8086);
        SRC.pulses(10);
        repeat (8) @(posedge pclk);
        rchk("ext sync count", ACSBT_OFS_COUNT, 32'd10);
    endtask

    task automatic t_async;
        wr(ACSBT_OFS_CTRL, 32'h8002);
        wr(ACSBT_OFS_COUNT, 32'h1111);
        wr(ACSBT_OFS_COUNT, 32'h1234);
        rchk("pending set", ACSBT_OFS_CTRL, 32'h8802);
        rchk("count held", ACSBT_OFS_COUNT, 32'd10);
        SRC.pulses(1);
        repeat (8) @(posedge pclk);
        rchk("pending clear", ACSBT_OFS_CTRL, 32'h8002);
        rrng("async load", 32'h1234, 32'h1235);
        wr(ACSBT_OFS_CTRL, 32'h9002);
        wr(ACSBT_OFS_COUNT, 32'h0100);
        wr(ACSBT_OFS_COUNT, 32'h0200);
        SRC.pulses(1);
        repeat (8) @(posedge pclk);
        rrng("blocked write", 32'h0100, 32'h0101);
        wr(ACSBT_OFS_CTRL, 32'h0);
    endtask

    task automatic t_period;
        wr(ACSBT_OFS_PERIOD, 32'h3);
        wr(ACSBT_OFS_COUNT, 32'h0);
        wr(ACSBT_OFS_STATUS, 32'h1);
        wr(ACSBT_OFS_CTRL, 32'h8000);
        repeat (20) @(posedge pclk);
        wr(ACSBT_OFS_CTRL, 32'h0);
        rrng("wrap count", 32'h0, 32'h3);
        rchk("flag set", ACSBT_OFS_STATUS, 32'h1);
        chk("flag pin", 32'h1, {31'h0, timer_flag});
        wr(ACSBT_OFS_STATUS, 32'h1);
        rchk("flag cleared", ACSBT_OFS_STATUS, 32'h0);
        wr(ACSBT_OFS_PERIOD, 32'hffff);
    endtask

    initial
    begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        test_done;
    end

    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_alias;
        t_bus_err;
        t_prescale;
        t_gate;
        t_idle;
        t_ext;
        t_async;
        t_period;
        test_done;
    end
endmodule
